// ### rtl/rct_regs.svh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef RCT_REGS_SVH
`define RCT_REGS_SVH

// ==========================================================
// Register byte offsets
`define RCT_OFS_CTRL 8'h00
`define RCT_OFS_CLK 8'h04
`define RCT_OFS_RLD_LO 8'h08
`define RCT_OFS_RLD_HI 8'h0C
`define RCT_OFS_CNT_LO 8'h10
`define RCT_OFS_CNT_HI 8'h14

// ==========================================================
// Control register fields
`define RCT_CTL_HFLAG 7
`define RCT_CTL_LFLAG 6
`define RCT_CTL_LIRQEN 5
`define RCT_CTL_CAPEN 4
`define RCT_CTL_SPLIT 3
`define RCT_CTL_RUN 2
`define RCT_CTL_XCLK_HI 1
`define RCT_CTL_XCLK_LO 0

// ==========================================================
// Clock control register fields
`define RCT_CLK_LSEL 0
`define RCT_CLK_HSEL 1
`define RCT_CLK_IRQEN 2

// ==========================================================
// Reset values and the full count byte value
`define RCT_CTRL_RST 8'h00
`define RCT_CLK_RST 3'h0
`define RCT_BYTE_RST 8'h00
`define RCT_BYTE_MAX 8'hFF

// ==========================================================
// Timing: system clock divided by 12
`define RCT_DIV12_LAST 4'hB
`define RCT_DIV12_RST 4'h0

`endif

// ### rtl/rct_pkg.sv
// Types shared by the reload and capture timer
package rct_pkg;

    // ==========================================================
    // External clock selection codes
    typedef enum logic [1:0] {
        RCT_SRC_DIV12 = 2'b00,
        RCT_SRC_RTC8 = 2'b01,
        RCT_SRC_RSVD = 2'b10,
        RCT_SRC_CMP = 2'b11
    } rct_src_t;

    typedef logic [7:0] rct_byte_t;
    typedef logic [31:0] rct_word_t;
    typedef logic [7:0] rct_addr_t;

endpackage

// ### rtl/rct_timer.sv
// Reload and capture timer: 16-bit or dual 8-bit auto-reload counter with APB slave
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "rct_regs.svh"

module rct_timer (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire rct_pkg::rct_addr_t paddr,
    input wire rct_pkg::rct_word_t pwdata,
    output rct_pkg::rct_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rtc_div8,
    input wire logic cmp_out,
    output logic irq
);
    import rct_pkg::*;

    // ==========================================================
    // Source selection, shared by both bytes
    function automatic logic src_tick(
        input logic sys_sel,
        input rct_src_t xsel,
        input logic t12,
        input logic trtc,
        input logic tcmp
    );
        logic t;
        t = 1'b0;
        if (sys_sel) begin
            t = 1'b1;
        end else begin
            case (xsel)
                RCT_SRC_DIV12: t = t12;
                RCT_SRC_RTC8: t = trtc;
                RCT_SRC_CMP: t = tcmp;
                default: t = 1'b0;
            endcase
        end
        return t;
    endfunction

    // ==========================================================
    // Registers
    logic hflag_q;
    logic hflag_d;
    logic lflag_q;
    logic lflag_d;
    logic lirq_en_q;
    logic cap_en_q;
    logic split_q;
    logic run_q;
    rct_src_t xclk_q;
    logic lsel_q;
    logic hsel_q;
    logic irq_en_q;
    rct_byte_t rld_lo_q;
    rct_byte_t rld_lo_d;
    rct_byte_t rld_hi_q;
    rct_byte_t rld_hi_d;
    rct_byte_t cnt_lo_q;
    rct_byte_t cnt_lo_d;
    rct_byte_t cnt_hi_q;
    rct_byte_t cnt_hi_d;
    logic [3:0] div12_q;
    logic rtc_s1_q;
    logic rtc_s2_q;
    logic rtc_s3_q;
    logic cmp_s1_q;
    logic cmp_s2_q;
    logic cmp_s3_q;

    // ==========================================================
    // APB decode
    wire logic wr_acc = psel & penable & pwrite;
    wire logic hit_ctrl = paddr == `RCT_OFS_CTRL;
    wire logic hit_clk = paddr == `RCT_OFS_CLK;
    wire logic hit_rlo = paddr == `RCT_OFS_RLD_LO;
    wire logic hit_rhi = paddr == `RCT_OFS_RLD_HI;
    wire logic hit_clo = paddr == `RCT_OFS_CNT_LO;
    wire logic hit_chi = paddr == `RCT_OFS_CNT_HI;
    wire logic hit_any = hit_ctrl | hit_clk | hit_rlo | hit_rhi | hit_clo | hit_chi;
    wire logic wr_ctrl = wr_acc & hit_ctrl;
    wire logic wr_clk = wr_acc & hit_clk;
    wire logic wr_rlo = wr_acc & hit_rlo;
    wire logic wr_rhi = wr_acc & hit_rhi;
    wire logic wr_clo = wr_acc & hit_clo;
    wire logic wr_chi = wr_acc & hit_chi;

    // Zero wait states; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit_any;

    wire rct_byte_t ctrl_rd = {hflag_q, lflag_q, lirq_en_q, cap_en_q,
                               split_q, run_q, xclk_q};
    wire rct_byte_t clk_rd = {5'h00, irq_en_q, hsel_q, lsel_q};

    assign prdata = hit_ctrl ? {24'h000000, ctrl_rd} :
                    hit_clk ? {24'h000000, clk_rd} :
                    hit_rlo ? {24'h000000, rld_lo_q} :
                    hit_rhi ? {24'h000000, rld_hi_q} :
                    hit_clo ? {24'h000000, cnt_lo_q} :
                    hit_chi ? {24'h000000, cnt_hi_q} :
                    32'h00000000;

    // ==========================================================
    // Tick sources
    wire logic div12_tick = div12_q == `RCT_DIV12_LAST;
    // Only the second and third stages feed the edge detectors
    wire logic rtc_tick = rtc_s2_q & ~rtc_s3_q;
    wire logic cmp_tick = cmp_s2_q & ~cmp_s3_q;

    wire logic lo_src = src_tick(lsel_q, xclk_q, div12_tick, rtc_tick, cmp_tick);
    wire logic hi_src = src_tick(hsel_q, xclk_q, div12_tick, rtc_tick, cmp_tick);

    // ==========================================================
    // Count steps
    // 16-bit mode is paced by the low byte select and gated by run
    wire logic step16 = ~split_q & run_q & lo_src;
    wire logic step_lo = split_q ? lo_src : step16;
    wire logic step_hi = split_q & run_q & hi_src;

    wire logic lo_full = cnt_lo_q == `RCT_BYTE_MAX;
    wire logic hi_full = cnt_hi_q == `RCT_BYTE_MAX;
    wire logic lo_wrap = step_lo & lo_full;
    wire logic ovf16 = step16 & lo_full & hi_full;
    wire logic hi_wrap = step_hi & hi_full;

    // Capture event: bit 1 of the external select picks the source
    wire logic cap_src = xclk_q[1] ? cmp_tick : rtc_tick;
    wire logic cap_evt = cap_en_q & cap_src;

    wire logic set_h = ovf16 | hi_wrap | cap_evt;
    wire logic set_l = lo_wrap;

    // ==========================================================
    // Next-state logic
    always_comb begin
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        if (split_q) begin
            if (step_lo) begin
                cnt_lo_d = lo_full ? rld_lo_q : cnt_lo_q + 8'h01;
            end
            if (step_hi) begin
                cnt_hi_d = hi_full ? rld_hi_q : cnt_hi_q + 8'h01;
            end
        end else if (step16) begin
            if (ovf16) begin
                cnt_lo_d = rld_lo_q;
                cnt_hi_d = rld_hi_q;
            end else begin
                {cnt_hi_d, cnt_lo_d} = {cnt_hi_q, cnt_lo_q} + 16'h0001;
            end
        end
        // Software writes to a count byte override that cycle's step
        if (wr_clo) begin
            cnt_lo_d = pwdata[7:0];
        end
        if (wr_chi) begin
            cnt_hi_d = pwdata[7:0];
        end
    end

    always_comb begin
        rld_lo_d = rld_lo_q;
        rld_hi_d = rld_hi_q;
        if (wr_rlo) begin
            rld_lo_d = pwdata[7:0];
        end
        if (wr_rhi) begin
            rld_hi_d = pwdata[7:0];
        end
        // Capture wins over a software write in the same cycle
        if (cap_evt) begin
            rld_lo_d = cnt_lo_q;
            rld_hi_d = cnt_hi_q;
        end
    end

    // Flags: hardware set beats a software clear in the same cycle
    always_comb begin
        hflag_d = hflag_q;
        lflag_d = lflag_q;
        if (wr_ctrl) begin
            hflag_d = pwdata[`RCT_CTL_HFLAG];
            lflag_d = pwdata[`RCT_CTL_LFLAG];
        end
        if (set_h) begin
            hflag_d = 1'b1;
        end
        if (set_l) begin
            lflag_d = 1'b1;
        end
    end

    // ==========================================================
    // Interrupt request: level, held while an enabled flag is set
    // Software must inspect both flags to tell the source apart
    assign irq = irq_en_q & (hflag_q | (lirq_en_q & lflag_q));

    // ==========================================================
    // Control state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lirq_en_q <= 1'b0;
            cap_en_q <= 1'b0;
            split_q <= 1'b0;
            run_q <= 1'b0;
            xclk_q <= RCT_SRC_DIV12;
        end else if (wr_ctrl) begin
            lirq_en_q <= pwdata[`RCT_CTL_LIRQEN];
            cap_en_q <= pwdata[`RCT_CTL_CAPEN];
            split_q <= pwdata[`RCT_CTL_SPLIT];
            run_q <= pwdata[`RCT_CTL_RUN];
            xclk_q <= rct_src_t'(pwdata[`RCT_CTL_XCLK_HI:`RCT_CTL_XCLK_LO]);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {irq_en_q, hsel_q, lsel_q} <= `RCT_CLK_RST;
        end else if (wr_clk) begin
            lsel_q <= pwdata[`RCT_CLK_LSEL];
            hsel_q <= pwdata[`RCT_CLK_HSEL];
            irq_en_q <= pwdata[`RCT_CLK_IRQEN];
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hflag_q <= 1'b0;
            lflag_q <= 1'b0;
        end else begin
            hflag_q <= hflag_d;
            lflag_q <= lflag_d;
        end
    end

    // ==========================================================
    // Count and reload bytes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_lo_q <= `RCT_BYTE_RST;
            cnt_hi_q <= `RCT_BYTE_RST;
        end else begin
            cnt_lo_q <= cnt_lo_d;
            cnt_hi_q <= cnt_hi_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rld_lo_q <= `RCT_BYTE_RST;
            rld_hi_q <= `RCT_BYTE_RST;
        end else begin
            rld_lo_q <= rld_lo_d;
            rld_hi_q <= rld_hi_d;
        end
    end

    // ==========================================================
    // System clock divided by 12, free running
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div12_q <= `RCT_DIV12_RST;
        end else if (div12_tick) begin
            div12_q <= `RCT_DIV12_RST;
        end else begin
            div12_q <= div12_q + 4'h1;
        end
    end

    // ==========================================================
    // Synchronisers; the third stage only remembers the last level
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rtc_s1_q <= 1'b0;
            rtc_s2_q <= 1'b0;
            rtc_s3_q <= 1'b0;
        end else begin
            rtc_s1_q <= rtc_div8;
            rtc_s2_q <= rtc_s1_q;
            rtc_s3_q <= rtc_s2_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
            cmp_s3_q <= 1'b0;
        end else begin
            cmp_s1_q <= cmp_out;
            cmp_s2_q <= cmp_s1_q;
            cmp_s3_q <= cmp_s2_q;
        end
    end

endmodule // rct_timer

// ### tb/rct_timer_asserts.sv
// Port checker for the reload and capture timer
`timescale 1ns/10ps
module rct_timer_asserts (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire rct_pkg::rct_addr_t paddr,
    input wire rct_pkg::rct_word_t pwdata,
    input wire rct_pkg::rct_word_t prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rtc_div8,
    input wire logic cmp_out,
    input wire logic irq
);
    import rct_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Bus decode
    wire acc = psel && penable;
    wire rd = acc && !pwrite;
    wire hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    wire rctl = rd && paddr == 8'h00;
    // ==========================================================
    // Properties
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_phase: assert property (pslverr |-> acc && !hit) else $error("stray pslverr");
    chk_unmapped_err: assert property (acc && !hit |-> pslverr) else $error("no pslverr");
    chk_unmapped_zero: assert property (rd && !hit |-> prdata == 32'h0) else $error("rdata");
    chk_upper_zero: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper bits");
    chk_irq_flag: assert property (rctl && irq |-> prdata[7] || prdata[6])
        else $error("irq without flag");
    chk_low_irq: assert property (rctl && irq && !prdata[7] |-> prdata[5])
        else $error("low irq not enabled");
    // Irq enable cleared: no request in the two cycles after the write
    chk_irq_enable: assert property (acc && pwrite && paddr == 8'h04 && !pwdata[2]
        |=> !irq [*2]) else $error("irq while disabled");
    chk_flag_hold: assert property ($fell(irq) |-> $past(acc && pwrite))
        else $error("flag cleared by hardware");
    cover property ($rose(irq));
    cover property (acc && !hit);
    cover property (rd && paddr == 8'h08);
endmodule // rct_timer_asserts

// ### tb/rct_timer_tb.sv
// Self-checking bench for the reload and capture timer
`timescale 1ns/10ps
module rct_timer_tb;
    import rct_pkg::*;
    typedef struct {rct_addr_t a; rct_byte_t d; rct_byte_t e; logic err;} rct_row_t;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    rct_addr_t paddr = 8'h00;
    rct_word_t pwdata = 32'h0;
    logic rtc_div8 = 1'h0;
    logic cmp_out = 1'h0;
    rct_word_t prdata;
    logic pready;
    logic pslverr;
    logic irq;
    rct_word_t rdat;
    logic rerr;
    int error_cnt = 0;
    int cmp_count = 0;
    // Clock reg row drops bits above the three it holds
    rct_row_t rows[6] = '{'{8'h08, 8'hA5, 8'hA5, 1'h0}, '{8'h0C, 8'h5A, 8'h5A, 1'h0},
        '{8'h10, 8'h33, 8'h33, 1'h0}, '{8'h14, 8'h44, 8'h44, 1'h0},
        '{8'h04, 8'hFB, 8'h03, 1'h0}, '{8'h1C, 8'hFF, 8'h00, 1'h1}};
    always #5 mclk = ~mclk;
    rct_timer DUT (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rtc_div8(rtc_div8), .cmp_out(cmp_out), .irq(irq));
    // ==========================================================
    // Tasks
    task automatic cmpw(input rct_word_t got, input rct_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmpb(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
        end
    endtask
    // Idle cycle at the end keeps back-to-back calls from double-driving psel
    task automatic apb(input logic w, input rct_addr_t a, input rct_byte_t d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'h1;
        @(posedge mclk);
        while (pready !== 1'h1 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge mclk);
    endtask
    task automatic wr(input rct_addr_t a, input rct_byte_t d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input rct_addr_t a, input rct_byte_t e);
        apb(1'h0, a, 8'h00);
        cmpw(rdat, {24'h0, e});
    endtask
    // Long enough for the two-flop synchroniser and edge detect
    task automatic pulse(input logic c);
        if (c)
            cmp_out <= 1'h1;
        else
            rtc_div8 <= 1'h1;
        repeat (4) @(posedge mclk);
        cmp_out <= 1'h0;
        rtc_div8 <= 1'h0;
        repeat (4) @(posedge mclk);
    endtask
    task automatic end_sim;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_sim;
    end
    // ==========================================================
    // Tests
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        @(posedge mclk);
        rd(8'h00, 8'h00);
        foreach (rows[i]) rd(rows[i].a, 8'h00);
        cmpb(irq, 1'h0);
        $display("Test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
            cmpb(rerr, rows[i].err);
        end
        $display("Test table done");
        wr(8'h14, 8'hFF);
        wr(8'h10, 8'hFE);
        wr(8'h08, 8'h10);
        wr(8'h0C, 8'h20);
        wr(8'h04, 8'h07);
        wr(8'h00, 8'h04);
        repeat (8) @(posedge mclk);
        rd(8'h00, 8'hC4);
        rd(8'h14, 8'h20);
        cmpb(irq, 1'h1);
        wr(8'h00, 8'h00);
        cmpb(irq, 1'h0);
        wr(8'h14, 8'h00);
        wr(8'h10, 8'hFE);
        wr(8'h00, 8'h24);
        repeat (8) @(posedge mclk);
        rd(8'h00, 8'h64);
        cmpb(irq, 1'h1);
        wr(8'h00, 8'h44);
        cmpb(irq, 1'h0);
        rd(8'h00, 8'h44);
        wr(8'h00, 8'h00);
        $display("Test wide mode done");
        wr(8'h04, 8'h03);
        wr(8'h14, 8'hFE);
        wr(8'h10, 8'hFE);
        wr(8'h08, 8'h11);
        wr(8'h0C, 8'h22);
        wr(8'h00, 8'h08);
        repeat (8) @(posedge mclk);
        rd(8'h00, 8'h48);
        rd(8'h14, 8'hFE);
        wr(8'h00, 8'h0C);
        repeat (8) @(posedge mclk);
        rd(8'h00, 8'h8C);
        apb(1'h0, 8'h14, 8'h00);
        cmpb(rdat[7:0] inside {[8'h22:8'h30]}, 1'h1);
        wr(8'h04, 8'h07);
        cmpb(irq, 1'h1);
        $display("Test split done");
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h04);
        wr(8'h10, 8'h34);
        wr(8'h14, 8'h12);
        wr(8'h00, 8'h11);
        pulse(1'h1);
        rd(8'h00, 8'h11);
        pulse(1'h0);
        rd(8'h08, 8'h34);
        rd(8'h0C, 8'h12);
        rd(8'h00, 8'h91);
        cmpb(irq, 1'h1);
        wr(8'h00, 8'h13);
        wr(8'h10, 8'hCD);
        wr(8'h14, 8'hAB);
        pulse(1'h0);
        rd(8'h00, 8'h13);
        pulse(1'h1);
        rd(8'h08, 8'hCD);
        rd(8'h0C, 8'hAB);
        $display("Test capture done");
        wr(8'h04, 8'h00);
        wr(8'h10, 8'h00);
        wr(8'h14, 8'h00);
        wr(8'h00, 8'h05);
        repeat (3) pulse(1'h0);
        rd(8'h10, 8'h03);
        wr(8'h00, 8'h07);
        repeat (2) pulse(1'h1);
        rd(8'h10, 8'h05);
        wr(8'h00, 8'h06);
        pulse(1'h0);
        pulse(1'h1);
        rd(8'h10, 8'h05);
        wr(8'h00, 8'h04);
        repeat (120) @(posedge mclk);
        wr(8'h00, 8'h06);
        apb(1'h0, 8'h10, 8'h00);
        cmpb(rdat[7:0] inside {[8'h0E:8'h11]}, 1'h1);
        $display("Test sources done");
        nrst <= 1'h0;
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        @(posedge mclk);
        rd(8'h10, 8'h00);
        rd(8'h00, 8'h00);
        $display("Test second reset done");
        end_sim;
    end
endmodule // rct_timer_tb

bind rct_timer rct_timer_asserts u_chk (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rtc_div8(rtc_div8), .cmp_out(cmp_out), .irq(irq));
